// ### design/afu_flag_update.sv
// accessed and dirty flag maintenance for descriptors seen by the table walker
`timescale 1ns/1ps
// Functional notes
// - capability output reports none, accessed only, or accessed plus dirty updates.
// - updates happen only when the stage's own enable bits allow them.
// - without update, clear accessed flag and fault-disable clear gives access fault.
// - descriptors with accessed flag clear are marked cacheable only when fault-disable is set.
// - access fault is checked before permission fault.
// - fault-disable set treats a clear accessed flag as set.
// - with update enabled, clear accessed flag is atomically set in memory.
// - hardware only sets the accessed flag, never clears it.
// - on permission fault the accessed flag is left untouched here.
// - every dirty update writes the accessed flag set as well.
// - clean-writable write becomes dirty; non-writable write faults; dirty write unchanged.
// - dirty modifier flag gates write promotion and is never changed.
// - dirty update clears stage 1 write-protect or sets stage 2 write bit.
module afu_flag_update (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] capSelect,
  output logic [1:0] flagUpdateCapabilityField,
  input wire logic reqValid,
  output logic reqReady,
  input wire afu_pkg::afu_req_t req,
  output logic casValid,
  output logic [47:0] casAddr,
  output logic [afu_pkg::DESC_W-1:0] casCompare,
  output logic [afu_pkg::DESC_W-1:0] casSwap,
  input wire logic casDone,
  input wire logic casSuccess,
  input wire logic [afu_pkg::DESC_W-1:0] casOld,
  output logic rspValid,
  output afu_pkg::afu_rsp_t rsp
);
  import afu_pkg::*;

  afu_state_t state_r;
  afu_req_t cur_r;
  logic [1:0] cap_r;
  logic [DESC_W-1:0] newDesc;
  logic needUpdate;
  logic [1:0] evalFault;
  logic afClear, writable, dirtyOk, accOk;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cap_r <= CAP_NONE;
    end else begin
      cap_r <= (capSelect > CAP_AF_DIRTY) ? CAP_AF_DIRTY : capSelect;
    end
  end
  assign flagUpdateCapabilityField = cap_r;

  always_comb begin
    accOk = (cap_r != CAP_NONE) && cur_r.hwAccessedUpdateEnable;
    dirtyOk = (cap_r == CAP_AF_DIRTY) && cur_r.hwDirtyUpdateEnable;
    afClear = !cur_r.desc[AF_BIT] && !cur_r.accessFaultDisable;
    writable = cur_r.stage2 ? cur_r.desc[S2AP1_BIT] : !cur_r.desc[AP2_BIT];
    newDesc = cur_r.desc;
    needUpdate = 1'b0;
    evalFault = FLT_NONE;
    if (afClear && !accOk) begin
      evalFault = FLT_ACCESS;
    end else begin
      if (afClear) begin
        newDesc[AF_BIT] = 1'b1;
        needUpdate = 1'b1;
      end
      if (cur_r.isWrite && !writable) begin
        if (cur_r.desc[DBM_BIT] && dirtyOk) begin
          if (cur_r.stage2) begin
            newDesc[S2AP1_BIT] = 1'b1;
          end else begin
            newDesc[AP2_BIT] = 1'b0;
          end
          if (!cur_r.desc[AF_BIT]) begin
            newDesc[AF_BIT] = 1'b1;
          end
          needUpdate = 1'b1;
        end else begin
          evalFault = FLT_PERM;
          needUpdate = 1'b0;
          newDesc = cur_r.desc;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (reqValid) begin
            state_r <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          state_r <= needUpdate ? ST_SWAP : ST_DONE;
        end
        ST_SWAP: begin
          if (casDone) begin
            // re-evaluate the stored value; a swapped descriptor needs no more update
            state_r <= ST_EVAL;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur_r <= '0;
    end else if (state_r == ST_IDLE && reqValid) begin
      cur_r <= req;
    end else if (state_r == ST_SWAP && casDone) begin
      cur_r.desc <= casSuccess ? casSwap : casOld;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reqReady <= 1'b0;
    end else begin
      reqReady <= (state_r == ST_IDLE) && !reqValid;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      casValid <= 1'b0;
      casAddr <= '0;
      casCompare <= '0;
      casSwap <= '0;
    end else begin
      if (state_r == ST_EVAL && needUpdate) begin
        casValid <= 1'b1;
        casAddr <= cur_r.addr;
        casCompare <= cur_r.desc;
        casSwap <= newDesc;
      end else if (casDone) begin
        casValid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rspValid <= 1'b0;
      rsp <= '0;
    end else begin
      rspValid <= 1'b0;
      if (state_r == ST_EVAL && !needUpdate) begin
        rspValid <= 1'b1;
        rsp.fault <= evalFault;
        rsp.desc <= cur_r.desc;
        rsp.cacheable <= (evalFault == FLT_NONE) &&
          (cur_r.desc[AF_BIT] || cur_r.accessFaultDisable);
      end
    end
  end
endmodule // afu_flag_update

// ### design/afu_pkg.sv
// package for the descriptor flag update block
package afu_pkg;
  localparam int DESC_W = 64;
  localparam int AF_BIT = 10;
  localparam int AP2_BIT = 7;
  localparam int S2AP1_BIT = 7;
  localparam int DBM_BIT = 51;
  localparam logic [1:0] CAP_NONE = 2'h0;
  localparam logic [1:0] CAP_AF = 2'h1;
  localparam logic [1:0] CAP_AF_DIRTY = 2'h2;
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_ACCESS = 2'h1;
  localparam logic [1:0] FLT_PERM = 2'h2;
  localparam logic [1:0] FLT_RETRY = 2'h3;

  typedef struct packed {
    logic [DESC_W-1:0] desc;
    logic [47:0] addr;
    logic stage2;
    logic isWrite;
    logic accessFaultDisable;
    logic hwAccessedUpdateEnable;
    logic hwDirtyUpdateEnable;
  } afu_req_t;

  typedef struct packed {
    logic [1:0] fault;
    logic cacheable;
    logic [DESC_W-1:0] desc;
  } afu_rsp_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_EVAL = 4'h2,
    ST_SWAP = 4'h4,
    ST_DONE = 4'h8
  } afu_state_t;
endpackage

// ### verif/afu_flag_update_checker.sv
// concurrent checks on the flag update block ports
`timescale 1ns/1ps
module afu_flag_update_checker import afu_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] capSelect,
  input wire logic [1:0] flagUpdateCapabilityField,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire afu_req_t req,
  input wire logic casValid,
  input wire logic [DESC_W-1:0] casCompare,
  input wire logic [DESC_W-1:0] casSwap,
  input wire logic casDone,
  input wire logic casSuccess,
  input wire logic rspValid,
  input wire afu_rsp_t rsp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence take_fault;
    reqValid && reqReady && !req.desc[AF_BIT] && !req.accessFaultDisable
      && !req.hwAccessedUpdateEnable;
  endsequence
  a_cap_clamp: assert property (capSelect == 2'h3 |=> flagUpdateCapabilityField == 2'h2)
    else $error("cap clamp");
  a_access_fault: assert property (take_fault |-> ##2 rspValid && rsp.fault == FLT_ACCESS)
    else $error("access fault");
  a_af_set: assert property (casValid |-> casSwap[AF_BIT]) else $error("af swap");
  a_dbm_kept: assert property (casValid |-> casSwap[DBM_BIT] == casCompare[DBM_BIT])
    else $error("dbm");
  a_cas_hold: assert property (casValid && !casDone |=> casValid && $stable(casSwap))
    else $error("cas hold");
  a_cas_drop: assert property (casDone |=> !casValid) else $error("cas drop");
  a_done_rsp: assert property (casDone && casSuccess |-> ##[1:2] rspValid)
    else $error("done rsp");
  a_rsp_pulse: assert property (rspValid |=> !rspValid) else $error("rsp pulse");
endmodule // afu_flag_update_checker
bind afu_flag_update afu_flag_update_checker i_chk (.*);

// ### verif/afu_flag_update_test.sv
// testbench for the flag update block
`timescale 1ns/1ps
module afu_flag_update_test;
  import afu_pkg::*;
  logic core_clk = 0, resetn = 0, reqValid = 0, reqReady, casValid, casDone, casSuccess, rspValid;
  logic [1:0] capSelect = 2'h3, flagUpdateCapabilityField;
  logic [3:0] lag = 4'h0;
  logic [47:0] casAddr;
  logic [63:0] casCompare, casSwap, casOld;
  afu_req_t req = '0;
  afu_rsp_t rsp;
  int err_total = 0, check_count = 0;
  localparam logic [63:0] A = 64'h400, W = 64'h80, M = 64'h8_0000_0000_0000;
  afu_flag_update i_dut (.*);
  afu_mem_model i_mem (.*);
  initial forever #12.5 core_clk = ~core_clk;
  task chk(input logic [63:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task run(input logic [63:0] d, m, input logic [4:0] f);
    i_mem.mem = m;
    @(posedge core_clk) reqValid <= 1'b1;
    req <= {d, 48'h1000, f};
    @(posedge core_clk) reqValid <= 1'b0;
    repeat (40) begin
      @(negedge core_clk);
      if (rspValid === 1'b1) return;
    end
    err_total++;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk(CAP_AF_DIRTY, flagUpdateCapabilityField);
    run('0, '0, 5'h00);
    chk(FLT_ACCESS, rsp.fault);
    chk('0, rsp.cacheable);
    run('0, '0, 5'h04);
    chk(FLT_NONE, rsp.fault);
    chk(1'b1, rsp.cacheable);
    run(W | M, W | M, 5'h08);
    chk(FLT_ACCESS, rsp.fault);
    lag = 4'h5;
    run('0, '0, 5'h02);
    chk(A, i_mem.mem);
    chk(64'h1000, casAddr);
    chk(A, rsp.desc);
    run(W | M, W | M, 5'h0b);
    chk(A | M, i_mem.mem);
    run(M, M, 5'h1b);
    chk(A | M | W, i_mem.mem);
    run(W | A, W | A, 5'h0b);
    chk(FLT_PERM, rsp.fault);
    run('0, A, 5'h02);
    chk(A, rsp.desc);
    @(posedge core_clk) capSelect <= 2'h0;
    run('0, '0, 5'h02);
    chk(FLT_ACCESS, rsp.fault);
    run(A, A, 5'h00);
    chk(FLT_NONE, rsp.fault);
    end_of_test;
  end
  initial begin
    #20us;
    err_total++;
    end_of_test;
  end
endmodule // afu_flag_update_test

// ### verif/afu_mem_model.sv
// memory answering descriptor compare-and-swap requests
`timescale 1ns/1ps
module afu_mem_model (
  input wire logic core_clk,
  input wire logic casValid,
  input wire logic [63:0] casCompare,
  input wire logic [63:0] casSwap,
  input wire logic [3:0] lag,
  output logic casDone,
  output logic casSuccess,
  output logic [63:0] casOld
);
  logic [63:0] mem;
  logic [3:0] cnt = 4'h0;
  initial {casDone, casSuccess, casOld} = '0;
  always @(posedge core_clk) begin
    casDone <= 1'b0;
    casSuccess <= ~casSuccess;
    casOld <= ~casOld;
    cnt <= (casValid && !casDone) ? cnt + 4'h1 : 4'h0;
    if (casValid && !casDone && cnt >= lag) begin
      casDone <= 1'b1;
      casOld <= mem;
      casSuccess <= mem === casCompare;
      if (mem === casCompare) mem <= casSwap;
    end
  end
endmodule // afu_mem_model
